// ---- design/pmx_pkg.sv ----
// Contract
// - Porta bit3 GPIO, or memory chip select low
// - Porta bit4 GPIO, or FIFO write strobe
// - Porta bit5 GPIO, or FIFO read strobe
// - Porta bit6 GPIO by default, else uart_a output
// - Uart_a output only in mode 0, else 1
// - Porta bit7 GPIO by default, else uart_b output
// - Uart_b output only mode 0; modes 1-3 drive 1
// - Portb bit0 GPIO, or timer 2 count input
// - Timer 2 ignores pin unless counter select set
// - Portb bit1 GPIO, or timer 2 external input
// - Portb bit2 GPIO, or uart_b receive input
// - Portb bit3 GPIO, or uart_b transmit line
// - Portb bit4 GPIO, or rising-edge interrupt four
// - Portb bit5 GPIO, or falling-edge interrupt five
// - Portb bit6 GPIO, or rising-edge interrupt six
package pmx_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_A_SEL     = 8'h00;
  localparam logic [7:0] OFF_A_SEL_ALT = 8'h04;
  localparam logic [7:0] OFF_B_SEL     = 8'h08;
  localparam logic [7:0] OFF_B_SEL_ALT = 8'h0C;
  localparam logic [7:0] OFF_A_OUT     = 8'h10;
  localparam logic [7:0] OFF_A_OE      = 8'h14;
  localparam logic [7:0] OFF_A_IN      = 8'h18;
  localparam logic [7:0] OFF_B_OUT     = 8'h1C;
  localparam logic [7:0] OFF_B_OE      = 8'h20;
  localparam logic [7:0] OFF_B_IN      = 8'h24;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int A_LO          = 3;
  localparam int A_HI          = 7;
  localparam int B_LO          = 0;
  localparam int B_HI          = 6;
  localparam int A_CS          = 3;
  localparam int A_FWR         = 4;
  localparam int A_FRD         = 5;
  localparam int A_RXA         = 6;
  localparam int A_RXB         = 7;
  localparam int B_T2          = 0;
  localparam int B_TIMER2_EXT_IN        = 1;
  localparam int B_RXB         = 2;
  localparam int B_TXB         = 3;
  localparam int B_IRQ4        = 4;
  localparam int B_IRQ5        = 5;
  localparam int B_IRQ6        = 6;
  localparam logic [7:0] SEL_RST   = 8'h00;
  localparam logic [7:0] GPIO_RST  = 8'h00;
  localparam logic [1:0] UART_MODE_SYNC = 2'h0;
  localparam logic       PAD_OUT_RST    = 1'b1;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       ext_mem_cs_n;
    logic       fifo_write_strobe_n;
    logic       fifo_read_strobe_n;
    logic       uart_a_rx_output;
    logic [1:0] uart_a_mode;
    logic       uart_b_rx_output;
    logic [1:0] uart_b_mode;
    logic       uart_b_tx_out;
    logic       timer2_counter_select;
  } pmx_core_out_t;

  typedef struct packed {
    logic timer2_count_in;
    logic timer2_ext_in;
    logic uart_b_rx_in;
    logic irq_four_rise;
    logic irq_five_fall_n;
    logic irq_six_rise;
  } pmx_core_in_t;

  localparam pmx_core_in_t CORE_IN_RST = '{
    timer2_count_in: 1'b0, timer2_ext_in: 1'b0, uart_b_rx_in: 1'b1,
    irq_four_rise: 1'b0, irq_five_fall_n: 1'b1, irq_six_rise: 1'b0};

endpackage

// ---- design/pmx_pin_cell.sv ----
`timescale 1ns/1ps
module pmx_pin_cell #(
  parameter logic OUT_RST = 1'b1
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Pad
  input  wire logic pad_in,
  output logic      pad_out,
  output logic      pad_oe,
  // Function sources
  input  wire logic gpio_out,
  input  wire logic gpio_oe,
  input  wire logic alt_sel,
  input  wire logic alt_out,
  input  wire logic alt_oe,
  // Synchronised pad level
  output logic      pin_level
);

  logic sync_a;
  logic next_pad_out;
  logic next_pad_oe;

  // ----------------------------------------------------------------
  // Output selection
  // ----------------------------------------------------------------
  always_comb begin
    next_pad_out = alt_sel ? alt_out : gpio_out;
    next_pad_oe  = alt_sel ? alt_oe  : gpio_oe;
  end

  // Output enable low at reset so the pad floats as an input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out   <= OUT_RST;
      pad_oe    <= 1'b0;
      sync_a    <= 1'b0;
      pin_level <= 1'b0;
    end else begin
      pad_out   <= next_pad_out;
      pad_oe    <= next_pad_oe;
      sync_a    <= pad_in;
      pin_level <= sync_a;
    end
  end

endmodule // pmx_pin_cell

// ---- design/pmx_mux.sv ----
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module pmx_mux (
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Port A pads, bits 3 to 7
  input  wire logic [7:3]             porta_in,
  output logic      [7:3]             porta_out,
  output logic      [7:3]             porta_oe,
  // Port B pads, bits 0 to 6
  input  wire logic [6:0]             portb_in,
  output logic      [6:0]             portb_out,
  output logic      [6:0]             portb_oe,
  // Processor side
  input  wire pmx_pkg::pmx_core_out_t core_out,
  output pmx_pkg::pmx_core_in_t       core_in
);

  logic [7:3] sel_a;
  logic [6:0] sel_b;
  logic [7:3] gpio_a_out;
  logic [7:3] gpio_a_oe;
  logic [6:0] gpio_b_out;
  logic [6:0] gpio_b_oe;
  logic [7:3] next_sel_a;
  logic [6:0] next_sel_b;
  logic [7:3] next_gpio_a_out;
  logic [7:3] next_gpio_a_oe;
  logic [6:0] next_gpio_b_out;
  logic [6:0] next_gpio_b_oe;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        addr_hit;
  logic        wr_en;
  logic [7:3]  alt_a_out;
  logic [7:3]  alt_a_oe;
  logic [6:0]  alt_b_out;
  logic [6:0]  alt_b_oe;
  logic [7:3]  a_level;
  logic [6:0]  b_level;
  logic [6:0]  b_prev;
  pmx_pkg::pmx_core_in_t next_core_in;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // One wait state keeps pready and prdata straight from flops
  always_comb begin
    addr_hit = 1'b1;
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      pmx_pkg::OFF_A_SEL:
        next_prdata[pmx_pkg::A_CS] = sel_a[pmx_pkg::A_CS];
      pmx_pkg::OFF_A_SEL_ALT:
        next_prdata[7:4] = sel_a[7:4];
      pmx_pkg::OFF_B_SEL:
        next_prdata[6:1] = sel_b[6:1];
      pmx_pkg::OFF_B_SEL_ALT:
        next_prdata[pmx_pkg::B_T2] = sel_b[pmx_pkg::B_T2];
      pmx_pkg::OFF_A_OUT: next_prdata[7:3] = gpio_a_out;
      pmx_pkg::OFF_A_OE:  next_prdata[7:3] = gpio_a_oe;
      pmx_pkg::OFF_A_IN:  next_prdata[7:3] = a_level;
      pmx_pkg::OFF_B_OUT: next_prdata[6:0] = gpio_b_out;
      pmx_pkg::OFF_B_OE:  next_prdata[6:0] = gpio_b_oe;
      pmx_pkg::OFF_B_IN:  next_prdata[6:0] = b_level;
      default:            addr_hit = 1'b0;
    endcase
    next_pready  = psel & penable & ~pready;
    next_pslverr = psel & penable & ~pready & ~addr_hit;
    if (!next_pready) begin
      next_prdata = prdata;
    end
    wr_en = psel & penable & pready & pwrite & addr_hit;
  end

  always_comb begin
    next_sel_a      = sel_a;
    next_sel_b      = sel_b;
    next_gpio_a_out = gpio_a_out;
    next_gpio_a_oe  = gpio_a_oe;
    next_gpio_b_out = gpio_b_out;
    next_gpio_b_oe  = gpio_b_oe;
    if (wr_en) begin
      unique case (paddr)
        pmx_pkg::OFF_A_SEL:
          next_sel_a[pmx_pkg::A_CS] = pwdata[pmx_pkg::A_CS];
        pmx_pkg::OFF_A_SEL_ALT: next_sel_a[7:4] = pwdata[7:4];
        pmx_pkg::OFF_B_SEL:     next_sel_b[6:1] = pwdata[6:1];
        pmx_pkg::OFF_B_SEL_ALT:
          next_sel_b[pmx_pkg::B_T2] = pwdata[pmx_pkg::B_T2];
        pmx_pkg::OFF_A_OUT: next_gpio_a_out = pwdata[7:3];
        pmx_pkg::OFF_A_OE:  next_gpio_a_oe  = pwdata[7:3];
        pmx_pkg::OFF_B_OUT: next_gpio_b_out = pwdata[6:0];
        pmx_pkg::OFF_B_OE:  next_gpio_b_oe  = pwdata[6:0];
        default: ;
      endcase
    end
  end

  // Selections clear at reset, every pin an input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_a      <= pmx_pkg::SEL_RST[7:3];
      sel_b      <= pmx_pkg::SEL_RST[6:0];
      gpio_a_out <= pmx_pkg::GPIO_RST[7:3];
      gpio_a_oe  <= pmx_pkg::GPIO_RST[7:3];
      gpio_b_out <= pmx_pkg::GPIO_RST[6:0];
      gpio_b_oe  <= pmx_pkg::GPIO_RST[6:0];
      prdata     <= 32'h0000_0000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
    end else begin
      sel_a      <= next_sel_a;
      sel_b      <= next_sel_b;
      gpio_a_out <= next_gpio_a_out;
      gpio_a_oe  <= next_gpio_a_oe;
      gpio_b_out <= next_gpio_b_out;
      gpio_b_oe  <= next_gpio_b_oe;
      prdata     <= next_prdata;
      pready     <= next_pready;
      pslverr    <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------
  // Alternate function sources
  // ----------------------------------------------------------------
  always_comb begin
    alt_a_out = '1;
    alt_a_oe  = '1;
    alt_b_out = '1;
    alt_b_oe  = '0;
    alt_a_out[pmx_pkg::A_CS]  = core_out.ext_mem_cs_n;
    alt_a_out[pmx_pkg::A_FWR] = core_out.fifo_write_strobe_n;
    alt_a_out[pmx_pkg::A_FRD] = core_out.fifo_read_strobe_n;
    // Async modes park the line high so it looks idle
    if (core_out.uart_a_mode == pmx_pkg::UART_MODE_SYNC) begin
      alt_a_out[pmx_pkg::A_RXA] = core_out.uart_a_rx_output;
    end
    if (core_out.uart_b_mode == pmx_pkg::UART_MODE_SYNC) begin
      alt_a_out[pmx_pkg::A_RXB] = core_out.uart_b_rx_output;
    end
    alt_b_out[pmx_pkg::B_TXB] = core_out.uart_b_tx_out;
    alt_b_oe[pmx_pkg::B_TXB]  = 1'b1;
  end

  // ----------------------------------------------------------------
  // Pad cells
  // ----------------------------------------------------------------
  for (genvar i = pmx_pkg::A_LO; i <= pmx_pkg::A_HI; i++) begin : g_pa
    pmx_pin_cell #(.OUT_RST(pmx_pkg::PAD_OUT_RST)) u_cell (
      .pclk      (pclk),
      .presetn   (presetn),
      .pad_in    (porta_in[i]),
      .pad_out   (porta_out[i]),
      .pad_oe    (porta_oe[i]),
      .gpio_out  (gpio_a_out[i]),
      .gpio_oe   (gpio_a_oe[i]),
      .alt_sel   (sel_a[i]),
      .alt_out   (alt_a_out[i]),
      .alt_oe    (alt_a_oe[i]),
      .pin_level (a_level[i])
    );
  end

  for (genvar j = pmx_pkg::B_LO; j <= pmx_pkg::B_HI; j++) begin : g_pb
    pmx_pin_cell #(.OUT_RST(pmx_pkg::PAD_OUT_RST)) u_cell (
      .pclk      (pclk),
      .presetn   (presetn),
      .pad_in    (portb_in[j]),
      .pad_out   (portb_out[j]),
      .pad_oe    (portb_oe[j]),
      .gpio_out  (gpio_b_out[j]),
      .gpio_oe   (gpio_b_oe[j]),
      .alt_sel   (sel_b[j]),
      .alt_out   (alt_b_out[j]),
      .alt_oe    (alt_b_oe[j]),
      .pin_level (b_level[j])
    );
  end

  // ----------------------------------------------------------------
  // Inputs towards the processor
  // ----------------------------------------------------------------
  // Deselected inputs rest at their idle level
  always_comb begin
    next_core_in = pmx_pkg::CORE_IN_RST;
    if (sel_b[pmx_pkg::B_T2] && core_out.timer2_counter_select) begin
      next_core_in.timer2_count_in = b_level[pmx_pkg::B_T2];
    end
    if (sel_b[pmx_pkg::B_TIMER2_EXT_IN]) begin
      next_core_in.timer2_ext_in = b_level[pmx_pkg::B_TIMER2_EXT_IN];
    end
    if (sel_b[pmx_pkg::B_RXB]) begin
      next_core_in.uart_b_rx_in = b_level[pmx_pkg::B_RXB];
    end
    next_core_in.irq_four_rise = sel_b[pmx_pkg::B_IRQ4]
      & b_level[pmx_pkg::B_IRQ4] & ~b_prev[pmx_pkg::B_IRQ4];
    next_core_in.irq_five_fall_n = ~(sel_b[pmx_pkg::B_IRQ5]
      & ~b_level[pmx_pkg::B_IRQ5] & b_prev[pmx_pkg::B_IRQ5]);
    next_core_in.irq_six_rise = sel_b[pmx_pkg::B_IRQ6]
      & b_level[pmx_pkg::B_IRQ6] & ~b_prev[pmx_pkg::B_IRQ6];
  end

  // History tracks even while deselected, so selecting gives no false edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_in <= pmx_pkg::CORE_IN_RST;
      b_prev  <= pmx_pkg::GPIO_RST[6:0];
    end else begin
      core_in <= next_core_in;
      b_prev  <= b_level;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_cs_pin;
    sel_a[3] |=> porta_oe[3] && porta_out[3] == $past(core_out.ext_mem_cs_n);
  endproperty
  a_cs_pin: assert property (p_cs_pin) else $error("cs pin wrong");

  property p_fwr_pin;
    sel_a[4] |=> porta_oe[4]
      && porta_out[4] == $past(core_out.fifo_write_strobe_n);
  endproperty
  a_fwr_pin: assert property (p_fwr_pin) else $error("fwr pin wrong");

  property p_frd_pin;
    sel_a[5] |=> porta_oe[5]
      && porta_out[5] == $past(core_out.fifo_read_strobe_n);
  endproperty
  a_frd_pin: assert property (p_frd_pin) else $error("frd pin wrong");

  property p_rxa_sync;
    sel_a[6] && core_out.uart_a_mode == 2'h0 |=> porta_oe[6]
      && porta_out[6] == $past(core_out.uart_a_rx_output);
  endproperty
  a_rxa_sync: assert property (p_rxa_sync) else $error("rxa data");

  property p_rxa_async;
    sel_a[6] && core_out.uart_a_mode != 2'h0 |=> porta_out[6];
  endproperty
  a_rxa_async: assert property (p_rxa_async) else $error("rxa not 1");

  property p_rxb_pin;
    sel_a[7] |=> porta_oe[7] && porta_out[7] ==
      ($past(core_out.uart_b_mode) == 2'h0 ?
       $past(core_out.uart_b_rx_output) : 1'b1);
  endproperty
  a_rxb_pin: assert property (p_rxb_pin) else $error("rxb pin wrong");

  property p_t2_gate;
    !(sel_b[0] && core_out.timer2_counter_select) |=> !core_in.timer2_count_in;
  endproperty
  a_t2_gate: assert property (p_t2_gate) else $error("t2 not gated");

  property p_t2_pass;
    sel_b[0] && core_out.timer2_counter_select
      |=> core_in.timer2_count_in == $past(b_level[0]);
  endproperty
  a_t2_pass: assert property (p_t2_pass) else $error("t2 not passed");

  property p_tx_pin;
    sel_b[3] |=> portb_oe[3] && portb_out[3] == $past(core_out.uart_b_tx_out);
  endproperty
  a_tx_pin: assert property (p_tx_pin) else $error("tx pin wrong");

  property p_irq4;
    core_in.irq_four_rise |-> $past(sel_b[4]) && $past(b_level[4])
      && !$past(b_level[4], 2);
  endproperty
  a_irq4: assert property (p_irq4) else $error("irq4 no rise");

  property p_irq5;
    !core_in.irq_five_fall_n |-> $past(sel_b[5]) && !$past(b_level[5])
      && $past(b_level[5], 2);
  endproperty
  a_irq5: assert property (p_irq5) else $error("irq5 no fall");

  property p_gpio_a;
    !sel_a[3] |=> porta_oe[3] == $past(gpio_a_oe[3])
      && porta_out[3] == $past(gpio_a_out[3]);
  endproperty
  a_gpio_a: assert property (p_gpio_a) else $error("gpio a wrong");

endmodule // pmx_mux

// ---- verif/pmx_far_side.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Far-side parts on the pads
// ------------------------------------------------------------------
module pmx_far_side (
  // Device pads
  input  wire logic [7:3] porta_out,
  input  wire logic [7:3] porta_oe,
  input  wire logic [6:0] portb_out,
  input  wire logic [6:0] portb_oe,
  // Levels the external parts push
  input  wire logic [7:3] a_push,
  input  wire logic [6:0] b_push,
  // Resolved wire levels
  output logic      [7:3] porta_in,
  output logic      [6:0] portb_in
);
  // Device drive wins; pushed level stands in for pull-ups when released
  assign porta_in = (porta_oe & porta_out) | (~porta_oe & a_push);
  assign portb_in = (portb_oe & portb_out) | (~portb_oe & b_push);
endmodule // pmx_far_side

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                   pclk;
  logic                   presetn;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [7:0]             paddr;
  logic [31:0]            pwdata;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic [7:3]             porta_in, porta_out, porta_oe, a_push;
  logic [6:0]             portb_in, portb_out, portb_oe, b_push;
  pmx_pkg::pmx_core_out_t core_out;
  pmx_pkg::pmx_core_in_t  core_in;
  logic [31:0]            seed, rdat, r;
  logic                   rerr;
  logic [7:0]             rv [8];
  logic [7:3]             sel_a;
  logic [6:0]             sel_b;
  logic [2:0]             irq_vec;
  int                     mismatches, cmp_count, cycles;
  // Select registers first, then GPIO out/oe; masks are writable bits
  logic [7:0] offs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c,
                           8'h10, 8'h14, 8'h1c, 8'h20};
  logic [7:0] msk  [8] = '{8'h08, 8'hf0, 8'h7e, 8'h01,
                           8'hf8, 8'hf8, 8'h7f, 8'h7f};

  assign sel_a   = {rv[1][7:4], rv[0][3]};
  assign sel_b   = {rv[2][6:1], rv[3][0]};
  assign irq_vec = {core_in.irq_six_rise, ~core_in.irq_five_fall_n,
                    core_in.irq_four_rise};

  pmx_mux pmx_mux_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .porta_in(porta_in),
    .porta_out(porta_out), .porta_oe(porta_oe), .portb_in(portb_in),
    .portb_out(portb_out), .portb_oe(portb_oe), .core_out(core_out),
    .core_in(core_in));

  pmx_far_side pmx_far_side_inst (
    .porta_out(porta_out), .porta_oe(porta_oe), .portb_out(portb_out),
    .portb_oe(portb_oe), .a_push(a_push), .b_push(b_push),
    .porta_in(porta_in), .portb_in(portb_in));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [7:3] alt_a();
    logic ua;
    logic ub;
    ua = (core_out.uart_a_mode == pmx_pkg::UART_MODE_SYNC) ?
         core_out.uart_a_rx_output : 1'b1;
    ub = (core_out.uart_b_mode == pmx_pkg::UART_MODE_SYNC) ?
         core_out.uart_b_rx_output : 1'b1;
    return {ub, ua, core_out.fifo_read_strobe_n,
            core_out.fifo_write_strobe_n, core_out.ext_mem_cs_n};
  endfunction

  task automatic wrap_up();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pwr(input int i, input logic [31:0] v);
    apb(1'b1, offs[i], v);
    rv[i] = v[7:0] & msk[i];
  endtask

  task automatic check_pads();
    logic [7:3] aoe;
    logic [7:3] aex;
    logic [6:0] boe;
    logic [6:0] bex;
    logic [5:0] ein;
    aoe = sel_a | rv[5][7:3];
    aex = (sel_a & alt_a()) | (~sel_a & rv[4][7:3]);
    boe = (sel_b & 7'h08) | (~sel_b & rv[7][6:0]);
    bex = (sel_b & {3'h0, core_out.uart_b_tx_out, 3'h0}) |
          (~sel_b & rv[6][6:0]);
    ein = {sel_b[0] & core_out.timer2_counter_select & b_push[0],
           sel_b[1] & b_push[1], ~sel_b[2] | b_push[2], 3'h2};
    chk(32'(porta_oe), 32'(aoe));
    chk(32'(porta_out & aoe), 32'(aex & aoe));
    chk(32'(portb_oe), 32'(boe));
    chk(32'(portb_out & boe), 32'(bex & boe));
    chk(32'(core_in), 32'(ein));
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, offs[i], 32'h0000_0000);
      chk(rdat, 32'(rv[i]));
    end
    apb(1'b0, pmx_pkg::OFF_A_IN, 32'h0000_0000);
    chk(rdat, {24'h0, (aoe & aex) | (~aoe & a_push), 3'h0});
    apb(1'b0, pmx_pkg::OFF_B_IN, 32'h0000_0000);
    chk(rdat, {25'h0, (boe & bex) | (~boe & b_push)});
  endtask

  // Counts active cycles of one interrupt line over eight clocks
  task automatic count_irq(input int k, input int expn);
    int n;
    n = 0;
    repeat (8) begin
      @(posedge pclk);
      #1;
      if (irq_vec[k] === 1'b1) n++;
    end
    chk(32'(n), 32'(expn));
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    cycles = 0;
    forever begin
      @(posedge pclk);
      cycles++;
      if (cycles == 20000) begin
        mismatches++;
        wrap_up();
      end
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    core_out = '0;
    a_push = '1;
    b_push = 7'h24;
    seed = 32'h0001_4ab4;
    mismatches = 0;
    cmp_count = 0;
    for (int i = 0; i < 8; i++) rv[i] = 8'h00;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    check_pads();
    // Unmapped: error flagged, reads zero, write lands nowhere
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
    chk(32'(rerr), 32'h0000_0001);
    apb(1'b1, 8'h44, 32'hffff_ffff);
    chk(32'(rerr), 32'h0000_0001);
    check_pads();
    // Random selects, GPIO, core sources and pad levels
    for (int n = 0; n < 40; n++) begin
      for (int i = 0; i < 8; i++) pwr(i, rnd());
      @(posedge pclk);
      r = rnd();
      core_out <= r[$bits(core_out)-1:0];
      a_push   <= r[15:11];
      b_push   <= r[22:16];
      repeat (8) @(posedge pclk);
      #1;
      check_pads();
    end
    // Every serial mode on both receive-output pins
    pwr(1, 32'h0000_00c0);
    for (int m = 0; m < 4; m++) begin
      @(posedge pclk);
      core_out.uart_a_mode      <= 2'(m);
      core_out.uart_b_mode      <= 2'(m);
      core_out.uart_a_rx_output <= 1'b0;
      core_out.uart_b_rx_output <= 1'b0;
      repeat (6) @(posedge pclk);
      #1;
      check_pads();
    end
    // Edge interrupts: one pulse per active edge, none otherwise
    pwr(7, 32'h0000_0000);
    for (int k = 0; k < 3; k++) begin
      @(posedge pclk);
      b_push[4+k] <= (k == 1);
      pwr(2, 32'h0000_0010 << k);
      repeat (6) @(posedge pclk);
      b_push[4+k] <= (k != 1);
      count_irq(k, 1);
      @(posedge pclk);
      b_push[4+k] <= (k == 1);
      count_irq(k, 0);
      pwr(2, 32'h0000_0000);
      b_push[4+k] <= (k != 1);
      count_irq(k, 0);
    end
    // Mid-run reset must bring every pin back to a plain input
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) rv[i] = 8'h00;
    repeat (4) @(posedge pclk);
    check_pads();
    wrap_up();
  end
endmodule // tb_top
